//--- rtl/slp_consts.svh
/*
 Constants for the synthesizer programming-word block: field positions,
 select codes, reset values and timing figures.
 Assumes inclusion by bare name from the package and the design module.
*/
// What this block does
// - Serial data shifts into a 24-bit register on rising serial clock, MSB first.
// - Latch strobe rising edge copies the shift register to the selected word.
// - Select bits 0,0 store the word into the control word.
// - Control word write at initial power-up powers the device and starts settling.
// - Chip-enable cycle with unchanged feedback word relocks in the same band.
// - Control-word power cycle with unchanged feedback word relocks in same band.
// - Power-down mode field: sync select bit 21, enable bit 20.
// - Enable 1 with sync select 0 powers down immediately.
// - Enable and sync both 1: power down on second reference edge after strobe.
// - Chip-enable low disables the device at once, whatever the bits say.
// - Power-down forces reference, feedback and timeout counters to load state.
// - Power-down forces the charge pump output to three-state.
// - Power-down resets digital lock detection, clearing the lock indication.
// - Power-down puts output stage high impedance, disables reference buffer.
// - Serial input register keeps accepting and latching words in power-down.
// - Two prescaler select bits choose the dual-modulus prescaler value.
// - Counter clear bit 4 holds reference and swallow/main counters in reset.
// - Pump gain bit is shared by control bit 10 and feedback bit 21, latest wins.
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH
`define SLP_WORD_W 24
`define SLP_SEL_CTRL 2'h0
`define SLP_SEL_REF 2'h1
`define SLP_SEL_FB 2'h2
`define SLP_SEL_TEST 2'h3
`define SLP_WORD_RST 24'h000000
`define SLP_BIT_PD_SYNC 21
`define SLP_BIT_PD_EN 20
`define SLP_BIT_CTRL_GAIN 10
`define SLP_BIT_CTRL_TRI 9
`define SLP_BIT_CLEAR 4
`define SLP_BIT_FB_GAIN 21
`define SLP_SYNC_EDGES 2'h2
`define SLP_SETTLE_LONG_NS 5000000
`define SLP_SETTLE_SHORT_NS 600000
`define SLP_CLK_NS 100
`endif

//--- rtl/slp_pkg.sv
/*
 Types for the synthesizer programming-word block.
 Assumes the constants header sits beside it.
*/
`include "slp_consts.svh"
package slp_pkg;
    typedef enum logic [2:0] {
        SLP_OFF = 3'h1,
        SLP_RUN = 3'h2,
        SLP_SYNC_WAIT = 3'h4
    } slp_pwr_t;

    typedef struct packed {
        logic prescaler_select_high;
        logic prescaler_select_low;
        logic powerdown_sync_select;
        logic powerdown_enable_bit;
        logic [2:0] pump_current_setting_two;
        logic [2:0] pump_current_setting_one;
        logic [1:0] output_drive_select;
        logic mute_until_locked;
        logic pump_gain_select;
        logic pump_three_state;
        logic detector_polarity;
        logic [2:0] monitor_select;
        logic counter_clear_bit;
        logic [1:0] core_current_select;
        logic [1:0] word_select;
    } slp_ctrl_t;

    typedef struct packed {
        logic halved_feed_select;
        logic output_halve_enable;
        logic pump_gain_select;
        logic [12:0] main_count;
        logic spare_bit;
        logic [4:0] swallow_count;
        logic [1:0] word_select;
    } slp_fb_t;

    typedef struct packed {
        logic [1:0] spare_bits;
        logic [1:0] band_clock_divider;
        logic factory_test_bit;
        logic lock_count_select;
        logic [1:0] pulse_width_select;
        logic [13:0] reference_divide;
        logic [1:0] word_select;
    } slp_ref_t;

    // Two-flop synchroniser per pin, plus one edge-history bit on serial clock, strobe and reference output
    typedef struct packed {
        logic [2:0] sclk;
        logic [1:0] sdata;
        logic [2:0] strobe;
        logic [1:0] ce;
        logic [2:0] refo;
    } slp_sync_t;

    typedef struct packed {
        slp_sync_t sy;
        logic [23:0] shift;
        slp_ctrl_t ctrl;
        slp_fb_t fb;
        slp_ref_t rref;
        logic gain;
        logic fb_dirty;
        logic powered_once;
        logic [1:0] sync_cnt;
        slp_pwr_t pwr;
        logic [1:0] last_sel;
        logic word_pulse;
    } slp_state_t;
endpackage

//--- rtl/slp_core.sv
/*
 Serial programming-word decode and power state control.
 Assumes serial clock, data, strobe, chip enable and reference counter
 output arrive asynchronously; serial clock is far slower than core clock.
*/
`timescale 1ns/1ps
`include "slp_consts.svh"
module slp_core (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Serial link
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic latch_strobe_in,
    // Pins and analog status
    input wire logic chip_enable_in,
    input wire logic ref_count_out_in,
    // Stored words
    output slp_pkg::slp_ctrl_t control_word_out,
    output slp_pkg::slp_fb_t feedback_divider_word_out,
    output slp_pkg::slp_ref_t reference_divider_word_out,
    output logic pump_gain_select_out,
    output logic [1:0] prescaler_select_out,
    output logic word_latched_out,
    output logic [1:0] word_latched_sel_out,
    // Power effects
    output logic powered_down_out,
    output logic counters_load_out,
    output logic pump_three_state_out,
    output logic lock_detect_reset_out,
    output logic output_stage_hiz_out,
    output logic ref_buffer_disable_out,
    output logic vco_bias_enable_out,
    output logic band_select_start_out,
    output logic feedback_changed_in_pd_out
);
    slp_pkg::slp_state_t st;
    slp_pkg::slp_state_t next_st;
    logic sclk_rise;
    logic strobe_rise;
    logic ref_rise;
    logic ce_low;
    logic [23:0] word;

    always_comb begin
        next_st = st;
        next_st.sy.sclk = {st.sy.sclk[1:0], serial_clk_in};
        next_st.sy.sdata = {st.sy.sdata[0], serial_data_in};
        next_st.sy.strobe = {st.sy.strobe[1:0], latch_strobe_in};
        next_st.sy.ce = {st.sy.ce[0], chip_enable_in};
        next_st.sy.refo = {st.sy.refo[1:0], ref_count_out_in};
        sclk_rise = st.sy.sclk[1] && !st.sy.sclk[2];
        strobe_rise = st.sy.strobe[1] && !st.sy.strobe[2];
        ref_rise = st.sy.refo[1] && !st.sy.refo[2];
        ce_low = !st.sy.ce[1];
        word = st.shift;
        next_st.word_pulse = 1'b0;
        if (sclk_rise) begin
            next_st.shift = {st.shift[22:0], st.sy.sdata[1]};
        end
        if (strobe_rise) begin
            next_st.word_pulse = 1'b1;
            next_st.last_sel = word[1:0];
            case (word[1:0])
                `SLP_SEL_CTRL: begin
                    next_st.ctrl = slp_pkg::slp_ctrl_t'(word);
                    next_st.gain = word[`SLP_BIT_CTRL_GAIN];
                    next_st.powered_once = 1'b1;
                    if (word[`SLP_BIT_PD_EN] && word[`SLP_BIT_PD_SYNC]) begin
                        if (st.pwr == slp_pkg::SLP_RUN) begin
                            next_st.pwr = slp_pkg::SLP_SYNC_WAIT;
                            next_st.sync_cnt = 2'h0;
                        end
                    end else if (word[`SLP_BIT_PD_EN]) begin
                        next_st.pwr = slp_pkg::SLP_OFF;
                    end else begin
                        // power up, fb word kept so band holds
                        next_st.pwr = slp_pkg::SLP_RUN;
                        next_st.fb_dirty = 1'b0;
                    end
                end
                `SLP_SEL_FB: begin
                    next_st.fb = slp_pkg::slp_fb_t'(word);
                    next_st.gain = word[`SLP_BIT_FB_GAIN];
                    if (st.pwr == slp_pkg::SLP_OFF || ce_low) begin
                        next_st.fb_dirty = 1'b1;
                    end
                end
                `SLP_SEL_REF: begin
                    next_st.rref = slp_pkg::slp_ref_t'(word);
                end
                // Factory test word is dropped on purpose
                `SLP_SEL_TEST: begin
                    next_st.last_sel = `SLP_SEL_TEST;
                end
                default: begin
                    next_st.last_sel = word[1:0];
                end
            endcase
        end
        if (st.pwr == slp_pkg::SLP_SYNC_WAIT && ref_rise) begin
            next_st.sync_cnt = st.sync_cnt + 2'h1;
            if (st.sync_cnt + 2'h1 == `SLP_SYNC_EDGES) begin
                next_st.pwr = slp_pkg::SLP_OFF;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
            st.pwr <= slp_pkg::SLP_OFF;
        end else begin
            st <= next_st;
        end
    end

    logic pd;
    assign pd = (st.pwr == slp_pkg::SLP_OFF) || ce_low;
    // band kept through chip-enable cycle: band restarts only on fb write
    assign band_select_start_out = st.word_pulse
        && st.last_sel == `SLP_SEL_FB;
    assign control_word_out = st.ctrl;
    assign feedback_divider_word_out = st.fb;
    assign reference_divider_word_out = st.rref;
    assign pump_gain_select_out = st.gain;
    assign prescaler_select_out = {st.ctrl.prescaler_select_high,
        st.ctrl.prescaler_select_low};
    assign word_latched_out = st.word_pulse;
    assign word_latched_sel_out = st.last_sel;
    assign powered_down_out = pd;
    assign counters_load_out = pd || st.ctrl.counter_clear_bit;
    assign pump_three_state_out = pd || st.ctrl.pump_three_state;
    assign lock_detect_reset_out = pd;
    // output stage and reference buffer off
    assign output_stage_hiz_out = pd;
    assign ref_buffer_disable_out = pd;
    // bias settles from first control write
    assign vco_bias_enable_out = !pd && st.powered_once;
    assign feedback_changed_in_pd_out = st.fb_dirty;

    chk_async_pd: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_CTRL
         && st.shift[20] && !st.shift[21]) |=> powered_down_out)
        else $error("async power-down missed");
    chk_ce_override: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ce_low |-> powered_down_out && output_stage_hiz_out)
        else $error("chip enable low not honoured");
    chk_sync_wait: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (st.pwr == slp_pkg::SLP_SYNC_WAIT && st.sync_cnt == 2'h0
         && ref_rise && !strobe_rise && st.sy.ce[0]) |=> !powered_down_out)
        else $error("sync power-down too early");
    chk_sync_done: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (st.pwr == slp_pkg::SLP_SYNC_WAIT && st.sync_cnt == 2'h1
         && ref_rise && !strobe_rise) |=> powered_down_out)
        else $error("sync power-down late");
    chk_pump_tri: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        powered_down_out |-> pump_three_state_out && counters_load_out
        && lock_detect_reset_out && ref_buffer_disable_out)
        else $error("power-down effects missing");
    chk_shift_msb: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        sclk_rise |=> st.shift[0] == $past(st.sy.sdata[1]))
        else $error("shift bit wrong");
    chk_ctrl_store: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_CTRL)
        |=> control_word_out == $past(st.shift))
        else $error("control word not stored");
    chk_gain_latest: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_FB)
        |=> pump_gain_select_out == $past(st.shift[21]))
        else $error("pump gain not latest");
    chk_clear_hold: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        st.ctrl.counter_clear_bit |-> counters_load_out)
        else $error("counter clear ignored");
    // earlier bits move up one place
    chk_shift_order: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        sclk_rise |=> st.shift[23:1] == $past(st.shift[22:0]))
        else $error("shift order wrong");
    chk_ref_store: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_REF)
        |=> reference_divider_word_out == $past(st.shift))
        else $error("reference word not stored");
    chk_fb_store: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_FB)
        |=> feedback_divider_word_out == $past(st.shift))
        else $error("feedback word not stored");
    // test word leaves stored words alone
    chk_test_drop: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && st.shift[1:0] == `SLP_SEL_TEST)
        |=> $stable(control_word_out) && $stable(feedback_divider_word_out)
        && $stable(reference_divider_word_out))
        else $error("test word reached a stored word");
    chk_latch_in_pd: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (strobe_rise && powered_down_out) |=> word_latched_out)
        else $error("latch lost in power-down");
    cov_sync: cover property (@(posedge core_clk_in)
        st.pwr == slp_pkg::SLP_SYNC_WAIT ##[1:200] powered_down_out);
    cov_fb: cover property (@(posedge core_clk_in) band_select_start_out);
    cov_ce: cover property (@(posedge core_clk_in)
        ce_low ##1 !ce_low);
    cov_test: cover property (@(posedge core_clk_in)
        word_latched_out && word_latched_sel_out == `SLP_SEL_TEST);
endmodule

//--- dv/slp_host.sv
/*
 Host model that writes 24-bit programming words over the three-wire link.
 Assumes the caller enters send just after a falling core clock edge.
*/
`timescale 1ns/1ps
module slp_host (
    // Clock
    input wire logic core_clk_in,
    // Serial link
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic latch_strobe_out
);
    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        latch_strobe_out = 1'b0;
    end

    // MSB first, 800 ns bit period
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data_out = w[i];
            repeat (4) @(negedge core_clk_in);
            serial_clk_out = 1'b1;
            repeat (4) @(negedge core_clk_in);
            serial_clk_out = 1'b0;
        end
        // Inverse keeps a stale bit from passing as valid
        serial_data_out = ~w[0];
        repeat (4) @(negedge core_clk_in);
        latch_strobe_out = 1'b1;
        repeat (4) @(negedge core_clk_in);
        latch_strobe_out = 1'b0;
    endtask
endmodule

//--- dv/testbench.sv
/*
 Self-checking bench comparing the block with a reference model.
 Assumes slp_pkg, slp_core and slp_host are compiled first.
*/
`timescale 1ns/1ps
`include "slp_consts.svh"
module testbench;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic chip_enable_in = 1'b1;
    logic ref_count_out_in = 1'b0;
    logic sclk, sdat, stb, gain_o, pd_o, load_o, tri_o, lock_o, hiz_o;
    logic rbd_o, bias_o, band_o, dirty_o, lat_o, pd;
    logic [1:0] psc_o, sel_o, m_sel;
    slp_pkg::slp_ctrl_t ctrl_o;
    slp_pkg::slp_fb_t fb_o;
    slp_pkg::slp_ref_t ref_o;
    logic [23:0] m_ctrl, m_fb, m_ref;
    logic m_gain, m_pd, m_dirty, m_bias;
    int m_band = 0, band_cnt = 0, m_lat = 0, lat_cnt = 0;
    int miscompares = 0, check_count = 0;
    localparam logic [23:0] CM = 24'h300210;

    always #50 core_clk_in = ~core_clk_in;

    slp_host i_slp_host (
        .core_clk_in(core_clk_in), .serial_clk_out(sclk),
        .serial_data_out(sdat), .latch_strobe_out(stb)
    );
    slp_core i_slp_core (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .serial_clk_in(sclk), .serial_data_in(sdat), .latch_strobe_in(stb),
        .chip_enable_in(chip_enable_in), .ref_count_out_in(ref_count_out_in),
        .control_word_out(ctrl_o), .feedback_divider_word_out(fb_o),
        .reference_divider_word_out(ref_o), .pump_gain_select_out(gain_o),
        .prescaler_select_out(psc_o), .word_latched_out(lat_o),
        .word_latched_sel_out(sel_o), .powered_down_out(pd_o),
        .counters_load_out(load_o), .pump_three_state_out(tri_o),
        .lock_detect_reset_out(lock_o), .output_stage_hiz_out(hiz_o),
        .ref_buffer_disable_out(rbd_o), .vco_bias_enable_out(bias_o),
        .band_select_start_out(band_o),
        .feedback_changed_in_pd_out(dirty_o)
    );

    always @(posedge core_clk_in) begin
        if (band_o === 1'b1) band_cnt++;
        if (lat_o === 1'b1) lat_cnt++;
    end

    task automatic cw(input string n, input logic [23:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic cb(input string n, input logic e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %b got %b", n, e, g);
        end
    endtask

    task automatic mreset;
        m_ctrl = 24'h0;
        m_fb = 24'h0;
        m_ref = 24'h0;
        m_sel = 2'h0;
        {m_gain, m_pd, m_dirty, m_bias} = 4'h4;
    endtask

    task automatic check_all;
        pd = m_pd | ~chip_enable_in;
        cw("ctrl", m_ctrl, ctrl_o);
        cw("fb", m_fb, fb_o);
        cw("ref", m_ref, ref_o);
        cw("sel", 24'(m_sel), 24'(sel_o));
        cw("latches", 24'(m_lat), 24'(lat_cnt));
        cw("bands", 24'(m_band), 24'(band_cnt));
        cw("psc", 24'(m_ctrl[23:22]), 24'(psc_o));
        cb("gain", m_gain, gain_o);
        cb("pd", pd, pd_o);
        cb("load", pd | m_ctrl[4], load_o);
        cb("tri", pd | m_ctrl[9], tri_o);
        cb("lock", pd, lock_o);
        cb("hiz", pd, hiz_o);
        cb("refbuf", pd, rbd_o);
        cb("bias", m_bias & ~pd, bias_o);
        cb("dirty", m_dirty, dirty_o);
    endtask

    // Random word with forced set and cleared bits
    task automatic wr(input logic [1:0] s, input logic [23:0] st, cl);
        logic [23:0] w;
        w = (24'($urandom()) & ~cl) | st;
        w[1:0] = s;
        i_slp_host.send(w);
        m_sel = s;
        m_lat++;
        if (s == 2'h0) begin
            m_ctrl = w;
            m_gain = w[10];
            m_bias = 1'b1;
            if (!w[20]) {m_pd, m_dirty} = 2'h0;
            else if (!w[21]) m_pd = 1'b1;
        end else if (s == 2'h2) begin
            m_fb = w;
            m_gain = w[21];
            m_band++;
            if (m_pd | ~chip_enable_in) m_dirty = 1'b1;
        end else if (s == 2'h1) begin
            m_ref = w;
        end
        repeat (4) @(negedge core_clk_in);
        check_all();
    endtask

    // ordered power-up with the short settle wait
    task automatic seq;
        wr(2'h1, 24'h0, 24'h0);
        wr(2'h0, 24'h0, CM);
        repeat (`SLP_SETTLE_SHORT_NS / `SLP_CLK_NS) @(negedge core_clk_in);
        wr(2'h2, 24'h0, 24'h0);
    endtask

    task automatic rp;
        ref_count_out_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        ref_count_out_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
    endtask

    task tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Run needs about 17k cycles; allow nearly three times that
    initial begin
        #5000000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(71711));
        mreset();
        repeat (5) @(negedge core_clk_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        check_all();
        seq();
        wr(2'h3, 24'h0, 24'h0);
        wr(2'h0, 24'h000400, CM);
        wr(2'h2, 24'h0, 24'h200000);
        wr(2'h0, 24'h000210, 24'h300000);
        wr(2'h0, 24'h100000, 24'h200210);
        wr(2'h2, 24'h0, 24'h0);
        wr(2'h0, 24'h0, CM);
        seq();
        wr(2'h0, 24'h100000, 24'h200210);
        wr(2'h0, 24'h0, CM);
        wr(2'h0, 24'h300000, 24'h000210);
        rp();
        check_all();
        rp();
        m_pd = 1'b1;
        check_all();
        wr(2'h0, 24'h0, CM);
        wr(2'h0, 24'h300000, 24'h000210);
        wr(2'h0, 24'h100000, 24'h200210);
        wr(2'h0, 24'h300000, 24'h000210);
        wr(2'h0, 24'h0, CM);
        chip_enable_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        check_all();
        chip_enable_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        check_all();
        chip_enable_in = 1'b0;
        wr(2'h2, 24'h0, 24'h0);
        chip_enable_in = 1'b1;
        wr(2'h0, 24'h0, CM);
        resetn_in = 1'b0;
        mreset();
        repeat (2) @(negedge core_clk_in);
        check_all();
        resetn_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        check_all();
        wr(2'h0, 24'h0, CM);
        tally_and_finish();
    end
endmodule
